/* hw/orient_trip_angle.sv */
// Orientation trip logic with settle counter and register port
//
// Strobed register access and the register addresses were left to the implementer.
`timescale 1ns/1ns
module orient_trip_angle (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Register port
  input wire orient_trip_pkg::reg_req_t req,
  output logic [7:0] rdata,
  // Samples, one strobe per output data period
  input wire orient_trip_pkg::sample_t smp,
  // Status
  output orient_trip_pkg::orient_t orientation,
  output logic orientation_changed_flag,
  output logic irq
);
  import orient_trip_pkg::*;

  typedef struct packed {
    logic [7:0] orientation_settle_count;
    logic [4:0] tilt_trip_code;
    logic [2:0] trip_hysteresis_code;
    logic int_mask;
    logic changed;
    orient_t orient;
    orient_t cand;
    logic [7:0] held;
    logic [7:0] rdata;
    logic irq;
  } state_t;

  state_t st;
  state_t next_st;
  logic [6:0] thr_deg;
  logic [6:0] trip_l2p;
  logic [6:0] trip_p2l;
  orient_t candidate;
  logic [7:0] next_held;
  logic change_event;

  orient_trip_cmp u_cmp (
    .tilt_trip_code(st.tilt_trip_code),
    .trip_hysteresis_code(st.trip_hysteresis_code),
    .x(smp.x),
    .y(smp.y),
    .orient(st.orient),
    .thr_deg(thr_deg),
    .trip_l2p(trip_l2p),
    .trip_p2l(trip_p2l),
    .candidate(candidate)
  );

  always_comb begin
    next_st = st;
    next_held = 8'h00;
    change_event = 1'b0;
    // Settle counter advances only on sample strobes
    if (smp.valid) begin
      if (candidate == st.orient) begin
        next_st.cand = st.orient;
        next_st.held = 8'h00;
      end else begin
        if (candidate == st.cand && st.held != 8'hff) begin
          next_held = st.held + 8'h01;
        end else if (candidate == st.cand) begin
          next_held = st.held;
        end else begin
          next_held = 8'h01;
        end
        next_st.cand = candidate;
        next_st.held = next_held;
        if (next_held >= st.orientation_settle_count) begin
          next_st.orient = candidate;
          next_st.held = 8'h00;
          change_event = 1'b1;
        end
      end
    end
    if (req.wr) begin
      case (req.addr)
        ADDR_SETTLE: begin
          next_st.orientation_settle_count = req.wdata;
        end
        ADDR_TRIP_CFG: begin
          next_st.tilt_trip_code = req.wdata[TILT_POS +: 5];
          next_st.trip_hysteresis_code = req.wdata[HYS_POS +: 3];
        end
        ADDR_INT_STATUS: begin
          if (req.wdata[0]) begin
            next_st.changed = 1'b0;
          end
        end
        ADDR_INT_MASK: begin
          next_st.int_mask = req.wdata[0];
        end
        default: begin
        end
      endcase
    end
    // A change in the same cycle as the clear is kept
    if (change_event) begin
      next_st.changed = 1'b1;
    end
    next_st.rdata = 8'h00;
    if (req.rd) begin
      case (req.addr)
        ADDR_SETTLE: next_st.rdata = st.orientation_settle_count;
        ADDR_TRIP_CFG: begin
          next_st.rdata = {st.tilt_trip_code, st.trip_hysteresis_code};
        end
        ADDR_ORIENT: begin
          next_st.rdata = {st.changed, 5'h00, st.orient};
        end
        ADDR_INT_STATUS: next_st.rdata = {7'h00, st.changed};
        ADDR_INT_MASK: next_st.rdata = {7'h00, st.int_mask};
        default: next_st.rdata = 8'h00;
      endcase
    end
    next_st.irq = next_st.changed & next_st.int_mask;
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st <= '{
        orientation_settle_count: SETTLE_RESET,
        tilt_trip_code: TILT_RESET,
        trip_hysteresis_code: HYS_RESET,
        int_mask: 1'b0,
        changed: 1'b0,
        orient: portrait_up,
        cand: portrait_up,
        held: 8'h00,
        rdata: 8'h00,
        irq: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign rdata = st.rdata;
  assign orientation = st.orient;
  assign orientation_changed_flag = st.changed;
  assign irq = st.irq;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  property p_thr_low;
    st.tilt_trip_code == 5'h00 |-> thr_deg == 7'h00;
  endproperty
  a_thr_low: assert property (p_thr_low)
    else $error("tilt code 0 not 0 degrees");

  property p_thr_mid;
    st.tilt_trip_code == 5'h10 && st.trip_hysteresis_code == 3'h0
      |-> trip_l2p == 7'h2d && trip_p2l == 7'h2d;
  endproperty
  a_thr_mid: assert property (p_thr_mid)
    else $error("tilt code 10h not 45 degrees");

  property p_thr_top;
    st.tilt_trip_code == 5'h1f |-> thr_deg == 7'h58;
  endproperty
  a_thr_top: assert property (p_thr_top)
    else $error("tilt code 1Fh not 88 degrees");

  property p_hys_sym;
    (thr_deg >= HYS_DEG[st.trip_hysteresis_code])
      && (trip_l2p < RIGHT_ANGLE)
      |-> (trip_l2p - thr_deg) == (thr_deg - trip_p2l);
  endproperty
  a_hys_sym: assert property (p_hys_sym)
    else $error("hysteresis band not symmetric");

  property p_def_widest;
    st.tilt_trip_code == 5'h10 && st.trip_hysteresis_code == 3'h7
      |-> trip_l2p == 7'h45 && trip_p2l == 7'h15;
  endproperty
  a_def_widest: assert property (p_def_widest)
    else $error("default widest band not 69/21");

  property p_reg_layout;
    req.rd && req.addr == ADDR_TRIP_CFG
      |=> rdata == {$past(st.tilt_trip_code), $past(st.trip_hysteresis_code)};
  endproperty
  a_reg_layout: assert property (p_reg_layout)
    else $error("trip config readback layout wrong");

  property p_class;
    $changed(orientation) |-> (orientation == landscape_right)
      ? !$past(smp.x[11]) : (orientation == landscape_left)
      ? $past(smp.x[11]) : (orientation == portrait_up)
      ? $past(smp.y[11]) : !$past(smp.y[11]);
  endproperty
  a_class: assert property (p_class)
    else $error("orientation disagrees with sample sign");

  property p_settle;
    $changed(orientation) |-> orientation_changed_flag
      && $past(smp.valid)
      && ($past(st.held) + 9'h001 >= {1'b0, $past(st.orientation_settle_count)});
  endproperty
  a_settle: assert property (p_settle)
    else $error("orientation reported before settling");

  property p_rdata_idle;
    !req.rd |=> rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not cleared after read cycle");

  // Flag stays until software writes a one to clear it
  property p_flag_sticky;
    orientation_changed_flag
      && !(req.wr && req.addr == ADDR_INT_STATUS && req.wdata[0])
      |=> orientation_changed_flag;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("change flag dropped without a clear");

  property p_hold;
    !smp.valid |=> $stable(orientation);
  endproperty
  a_hold: assert property (p_hold)
    else $error("orientation moved without a sample strobe");

  c_change: cover property ($changed(orientation));
  c_irq: cover property ($rose(irq));
  c_left: cover property (orientation == landscape_left);
  c_clear: cover property ($fell(orientation_changed_flag));

endmodule : orient_trip_angle

/* common/orient_trip_pkg.sv */
// Constants, tables and carrier types of the orientation trip logic
// Function
// - Tilt code maps monotonically to threshold angle
// - Top tilt code selects about 88 degrees
// - Hysteresis widens trip angles symmetrically where neither trip hits the 0..90 clamp
// - Default 45 degree threshold gives tabled trips
// - Y sign picks portrait, X sign landscape
// - Tilt code bits 7:3, hysteresis bits 2:0
// - New orientation held settle count before report
package orient_trip_pkg;

  localparam logic [7:0] ADDR_SETTLE = 8'h2a;
  localparam logic [7:0] ADDR_TRIP_CFG = 8'h2c;
  localparam logic [7:0] ADDR_ORIENT = 8'h30;
  localparam logic [7:0] ADDR_INT_STATUS = 8'h31;
  localparam logic [7:0] ADDR_INT_MASK = 8'h32;

  localparam int TILT_POS = 3;
  localparam int HYS_POS = 0;
  localparam int CHANGED_POS = 7;
  localparam logic [4:0] TILT_RESET = 5'h10;
  localparam logic [2:0] HYS_RESET = 3'h4;
  localparam logic [7:0] SETTLE_RESET = 8'h00;
  localparam logic [6:0] RIGHT_ANGLE = 7'h5a;

  // Threshold angle in whole degrees for each tilt code
  localparam logic [6:0] THR_DEG [0:31] = '{
    7'h00, 7'h02, 7'h04, 7'h06, 7'h08, 7'h0b, 7'h0d, 7'h10,
    7'h12, 7'h15, 7'h18, 7'h1c, 7'h1f, 7'h22, 7'h26, 7'h29,
    7'h2d, 7'h31, 7'h34, 7'h38, 7'h3b, 7'h3e, 7'h42, 7'h45,
    7'h48, 7'h4a, 7'h4d, 7'h50, 7'h52, 7'h54, 7'h56, 7'h58};

  // Hysteresis in whole degrees for each hysteresis code
  localparam logic [6:0] HYS_DEG [0:7] = '{
    7'h00, 7'h04, 7'h07, 7'h0b, 7'h0e, 7'h11, 7'h15, 7'h18};

  // Sine of 0..90 degrees scaled to 255
  localparam logic [7:0] SIN_TAB [0:90] = '{
    8'h00, 8'h04, 8'h09, 8'h0d, 8'h12, 8'h16, 8'h1b, 8'h1f, 8'h23, 8'h28,
    8'h2c, 8'h31, 8'h35, 8'h39, 8'h3e, 8'h42, 8'h46, 8'h4b, 8'h4f, 8'h53,
    8'h57, 8'h5b, 8'h60, 8'h64, 8'h68, 8'h6c, 8'h70, 8'h74, 8'h78, 8'h7c,
    8'h7f, 8'h83, 8'h87, 8'h8b, 8'h8f, 8'h92, 8'h96, 8'h99, 8'h9d, 8'ha0,
    8'ha4, 8'ha7, 8'hab, 8'hae, 8'hb1, 8'hb4, 8'hb7, 8'hba, 8'hbe, 8'hc0,
    8'hc3, 8'hc6, 8'hc9, 8'hcc, 8'hce, 8'hd1, 8'hd3, 8'hd6, 8'hd8, 8'hdb,
    8'hdd, 8'hdf, 8'he1, 8'he3, 8'he5, 8'he7, 8'he9, 8'heb, 8'hec, 8'hee,
    8'hf0, 8'hf1, 8'hf3, 8'hf4, 8'hf5, 8'hf6, 8'hf7, 8'hf8, 8'hf9, 8'hfa,
    8'hfb, 8'hfc, 8'hfd, 8'hfd, 8'hfe, 8'hfe, 8'hfe, 8'hff, 8'hff, 8'hff,
    8'hff};

  typedef enum logic [1:0] {
    portrait_up = 2'b00,
    portrait_down = 2'b01,
    landscape_right = 2'b10,
    landscape_left = 2'b11
  } orient_t;

  typedef struct packed {
    logic valid;
    logic signed [11:0] x;
    logic signed [11:0] y;
  } sample_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

endpackage : orient_trip_pkg

/* hw/orient_trip_cmp.sv */
// Tilt angle comparison against hysteresis-adjusted trip angles
`timescale 1ns/1ns
module orient_trip_cmp (
  // Configuration
  input wire logic [4:0] tilt_trip_code,
  input wire logic [2:0] trip_hysteresis_code,
  // Sample and present orientation
  input wire logic signed [11:0] x,
  input wire logic signed [11:0] y,
  input wire orient_trip_pkg::orient_t orient,
  // Results
  output logic [6:0] thr_deg,
  output logic [6:0] trip_l2p,
  output logic [6:0] trip_p2l,
  output orient_trip_pkg::orient_t candidate
);
  import orient_trip_pkg::*;

  function automatic logic [7:0] sin_of(input logic [6:0] deg);
    sin_of = SIN_TAB[deg];
  endfunction : sin_of

  logic [6:0] hys;
  logic [7:0] sum;
  logic [11:0] ax;
  logic [11:0] ay;
  logic [19:0] y_cos_l2p;
  logic [19:0] x_sin_l2p;
  logic [19:0] y_cos_p2l;
  logic [19:0] x_sin_p2l;
  logic was_portrait;
  logic portrait;

  always_comb begin
    thr_deg = THR_DEG[tilt_trip_code];
    hys = HYS_DEG[trip_hysteresis_code];
    sum = {1'b0, thr_deg} + {1'b0, hys};
    // Trip angles straddle the threshold, clamped to 0..90
    trip_l2p = (sum > {1'b0, RIGHT_ANGLE}) ? RIGHT_ANGLE : sum[6:0];
    trip_p2l = (thr_deg > hys) ? thr_deg - hys : 7'h00;
    ax = x[11] ? 12'(-x) : 12'(x);
    ay = y[11] ? 12'(-y) : 12'(y);
    // Angle away from the X axis beats T when |y|cos T > |x|sin T
    y_cos_l2p = ay * sin_of(7'(RIGHT_ANGLE - trip_l2p));
    x_sin_l2p = ax * sin_of(trip_l2p);
    y_cos_p2l = ay * sin_of(7'(RIGHT_ANGLE - trip_p2l));
    x_sin_p2l = ax * sin_of(trip_p2l);
    was_portrait = (orient == portrait_up) || (orient == portrait_down);
    portrait = was_portrait ? !(y_cos_p2l < x_sin_p2l)
                            : (y_cos_l2p > x_sin_l2p);
    if (portrait) begin
      candidate = y[11] ? portrait_up : portrait_down;
    end else begin
      candidate = x[11] ? landscape_left : landscape_right;
    end
  end

endmodule : orient_trip_cmp

/* dv/orientation_trip_angle_logic_tb.sv */
// Register and sample sequence bench for the orientation trip logic
`timescale 1ns/1ns
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  mismatches++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module orientation_trip_angle_logic_tb;
  import orient_trip_pkg::*;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  reg_req_t req = '0;
  sample_t smp = '0;
  logic [7:0] rdata;
  orient_t orientation;
  logic orientation_changed_flag;
  logic irq;
  int mismatches = 0;
  int samples_checked = 0;

  orient_trip_angle orient_trip_angle_i (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .req(req),
    .rdata(rdata),
    .smp(smp),
    .orientation(orientation),
    .orientation_changed_flag(orientation_changed_flag),
    .irq(irq)
  );

  always #25 ref_clk = ~ref_clk;

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge ref_clk);
    req.wr <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge ref_clk);
    req.rd <= 1'b0;
    #1;
    `CHK("rdata", e, rdata)
  endtask : rd

  // One sample strobe, then the result is settled after its edge
  task automatic samp(input int x, input int y);
    @(posedge ref_clk);
    smp <= '{valid: 1'b1, x: 12'(x), y: 12'(y)};
    @(posedge ref_clk);
    smp.valid <= 1'b0;
    #1;
  endtask : samp

  task automatic final_report;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report

  initial begin
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    rd(ADDR_TRIP_CFG, {TILT_RESET, HYS_RESET});
    rd(ADDR_SETTLE, 8'h00);
    rd(ADDR_ORIENT, 8'h00);
    rd(ADDR_INT_STATUS, 8'h00);
    rd(8'h55, 8'h00);
    wr(ADDR_INT_MASK, 8'h01);
    rd(ADDR_INT_MASK, 8'h01);
    // Read data stands one cycle only, then returns to zero
    @(posedge ref_clk);
    #1;
    `CHK("rdata idle", 8'h00, rdata)
    samp(1000, 0);
    `CHK("orient", landscape_right, orientation)
    `CHK("flag", 1'b1, orientation_changed_flag)
    `CHK("irq", 1'b1, irq)
    rd(ADDR_ORIENT, 8'h82);
    rd(ADDR_INT_STATUS, 8'h01);
    wr(ADDR_INT_STATUS, 8'h01);
    `CHK("irq", 1'b0, irq)
    // Default 45 +- 14: trips at 59 and 31 degrees
    samp(-643, 766);
    `CHK("orient", landscape_left, orientation)
    samp(-423, 906);
    `CHK("orient", portrait_down, orientation)
    samp(819, 574);
    `CHK("orient", portrait_down, orientation)
    samp(906, 423);
    `CHK("orient", landscape_right, orientation)
    wr(ADDR_INT_MASK, 8'h00);
    `CHK("irq", 1'b0, irq)
    wr(ADDR_INT_STATUS, 8'h01);
    `CHK("flag", 1'b0, orientation_changed_flag)
    // Settle count 3, with a candidate reset in between
    wr(ADDR_SETTLE, 8'h03);
    rd(ADDR_SETTLE, 8'h03);
    samp(-1000, 0);
    samp(1000, 0);
    samp(-1000, 0);
    samp(-1000, 0);
    `CHK("orient", landscape_right, orientation)
    `CHK("flag", 1'b0, orientation_changed_flag)
    samp(-1000, 0);
    `CHK("orient", landscape_left, orientation)
    `CHK("flag", 1'b1, orientation_changed_flag)
    wr(ADDR_SETTLE, 8'h00);
    // Threshold 0 degrees, no hysteresis
    wr(ADDR_TRIP_CFG, 8'h00);
    rd(ADDR_TRIP_CFG, 8'h00);
    samp(-1000, 20);
    `CHK("orient", portrait_down, orientation)
    // Threshold near 88 degrees
    wr(ADDR_TRIP_CFG, 8'hf8);
    samp(87, 996);
    `CHK("orient", landscape_right, orientation)
    // Threshold 45 degrees, no hysteresis
    wr(ADDR_TRIP_CFG, 8'h80);
    samp(643, 766);
    `CHK("orient", portrait_down, orientation)
    samp(-766, -643);
    `CHK("orient", landscape_left, orientation)
    samp(-423, -906);
    `CHK("orient", portrait_up, orientation)
    // Reset mid-run restores configuration and clears the flag
    rd(ADDR_ORIENT, 8'h80);
    @(posedge ref_clk);
    nrst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    rd(ADDR_TRIP_CFG, {TILT_RESET, HYS_RESET});
    rd(ADDR_SETTLE, SETTLE_RESET);
    rd(ADDR_ORIENT, 8'h00);
    rd(ADDR_INT_MASK, 8'h00);
    `CHK("irq", 1'b0, irq)
    final_report();
  end
endmodule : orientation_trip_angle_logic_tb
